// File: pkg/result_flags_pkg.sv
// constants and carriers for the sample result and fault flag register bank
package result_flags_pkg;

  localparam int unsigned DATA_W = 24;
  localparam int unsigned ADDR_W = 8;

  // word addresses of the registers held here
  localparam logic [7:0] ADDR_SECOND_AMBIENT = 8'h2D;
  localparam logic [7:0] ADDR_FIRST_NET = 8'h2E;
  localparam logic [7:0] ADDR_SECOND_NET = 8'h2F;
  localparam logic [7:0] ADDR_FAULT_FLAGS = 8'h30;

  localparam logic [23:0] RESULT_RESET = 24'h000000;
  localparam logic [23:0] FLAGS_RESET = 24'h000000;
  localparam logic [23:0] READ_UNMAPPED = 24'h000000;

  // fault flag field positions
  localparam int unsigned BIT_PD_ALARM = 12;
  localparam int unsigned BIT_EMITTER_ALARM = 11;
  localparam int unsigned FLAG_COUNT = 13;
  localparam logic [10:0] FLAGS_UPPER_ZERO = 11'h000;

  // per-conversion results from the sample engine
  typedef struct packed {
    logic [23:0] first_led;
    logic [23:0] first_ambient;
    logic [23:0] second_led;
    logic [23:0] second_ambient;
  } conversion_s;

  // raw fault detector levels, packed in register bit order 12 down to 0
  typedef struct packed {
    logic photodiode_alarm;
    logic emitter_alarm;
    logic second_emitter_open_flag;
    logic first_emitter_open_flag;
    logic emitter_short_flag;
    logic tx_pos_ground_short_flag;
    logic tx_neg_ground_short_flag;
    logic photodiode_open_flag;
    logic photodiode_short_flag;
    logic rx_neg_ground_short_flag;
    logic rx_pos_ground_short_flag;
    logic rx_neg_emitter_short_flag;
    logic rx_pos_emitter_short_flag;
  } fault_s;

endpackage

// File: design/sample_result_and_fault_flags.sv
// read-only sample result and fault flag register bank
`timescale 1ns/1ps
`default_nettype none

module sample_result_and_fault_flags (
  input wire logic clk,
  input wire logic srst,
  input wire logic conv_valid,
  input wire result_flags_pkg::conversion_s conv,
  input wire logic fault_flags_done,
  input wire result_flags_pkg::fault_s fault_levels,
  input wire logic alarm_pin_clock_monitor_enable,
  input wire logic monitor_clock_pd,
  input wire logic monitor_clock_emitter,
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [23:0] wr_data,
  output logic [23:0] rd_data,
  output logic data_ready,
  output logic diagnostic_complete_pin,
  output logic photodiode_alarm_pin,
  output logic emitter_alarm_pin
);

  // result registers and their next values
  logic [23:0] second_led_ambient_sample;
  logic [23:0] next_second_led_ambient_sample;
  logic [23:0] first_led_net_sample;
  logic [23:0] next_first_led_net_sample;
  logic [23:0] second_led_net_sample;
  logic [23:0] next_second_led_net_sample;
  logic next_data_ready;

  // latched diagnostic levels, kept in register bit order
  logic [12:0] fault_latched;
  logic [12:0] next_fault_latched;
  result_flags_pkg::fault_s fault_view;
  logic next_diagnostic_complete_pin;
  logic [23:0] fault_flags;

  // monitored clocks after two stages
  logic pd_clock_synced;
  logic emitter_clock_synced;

  // read path
  logic hit_second_ambient;
  logic hit_first_net;
  logic hit_second_net;
  logic hit_fault_flags;
  logic [23:0] next_rd_data;
  logic unused_write;

  // sampled only, so a monitored clock faster than half of clk aliases on the pin
  level_synchroniser #(
    .RESET_LEVEL(1'b0)
  ) pd_clock_sync (
    .clk(clk),
    .srst(srst),
    .async_in(monitor_clock_pd),
    .sync_out(pd_clock_synced)
  );

  level_synchroniser #(
    .RESET_LEVEL(1'b0)
  ) emitter_clock_sync (
    .clk(clk),
    .srst(srst),
    .async_in(monitor_clock_emitter),
    .sync_out(emitter_clock_synced)
  );

  // a conversion set arrives complete, so all results move on the same edge
  // no overrun flag is kept: a late host read simply sees the newer value
  always_comb begin
    next_second_led_ambient_sample = second_led_ambient_sample;
    if (conv_valid) begin
      next_second_led_ambient_sample = conv.second_ambient;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      second_led_ambient_sample <= result_flags_pkg::RESULT_RESET;
    end else begin
      second_led_ambient_sample <= next_second_led_ambient_sample;
    end
  end

  // subtraction wraps modulo 2^24, the register holds only 24 bits
  always_comb begin
    next_first_led_net_sample = first_led_net_sample;
    if (conv_valid) begin
      next_first_led_net_sample = conv.first_led - conv.first_ambient;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      first_led_net_sample <= result_flags_pkg::RESULT_RESET;
    end else begin
      first_led_net_sample <= next_first_led_net_sample;
    end
  end

  // second channel uses the same wrapping subtraction
  always_comb begin
    next_second_led_net_sample = second_led_net_sample;
    if (conv_valid) begin
      next_second_led_net_sample = conv.second_led - conv.second_ambient;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      second_led_net_sample <= result_flags_pkg::RESULT_RESET;
    end else begin
      second_led_net_sample <= next_second_led_net_sample;
    end
  end

  // one-cycle pulse; a host that misses it still finds the data in place
  always_comb begin
    next_data_ready = 1'b0;
    if (conv_valid) begin
      next_data_ready = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      data_ready <= 1'b0;
    end else begin
      data_ready <= next_data_ready;
    end
  end

  // flags move only on completion, never on a host write
  always_comb begin
    next_fault_latched = fault_latched;
    if (fault_flags_done) begin
      next_fault_latched = fault_levels;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fault_latched <= result_flags_pkg::FLAGS_RESET[12:0];
    end else begin
      fault_latched <= next_fault_latched;
    end
  end

  // pin pulses one cycle while the flags stay until the next sequence
  always_comb begin
    next_diagnostic_complete_pin = 1'b0;
    if (fault_flags_done) begin
      next_diagnostic_complete_pin = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      diagnostic_complete_pin <= 1'b0;
    end else begin
      diagnostic_complete_pin <= next_diagnostic_complete_pin;
    end
  end

  // struct view of the latch for access by field name
  always_comb begin
    fault_view = fault_latched;
  end

  // named fields keep the bit order tied to the carrier struct
  always_comb begin
    fault_flags = {
      result_flags_pkg::FLAGS_UPPER_ZERO,
      fault_view.photodiode_alarm,
      fault_view.emitter_alarm,
      fault_view.second_emitter_open_flag,
      fault_view.first_emitter_open_flag,
      fault_view.emitter_short_flag,
      fault_view.tx_pos_ground_short_flag,
      fault_view.tx_neg_ground_short_flag,
      fault_view.photodiode_open_flag,
      fault_view.photodiode_short_flag,
      fault_view.rx_neg_ground_short_flag,
      fault_view.rx_pos_ground_short_flag,
      fault_view.rx_neg_emitter_short_flag,
      fault_view.rx_pos_emitter_short_flag
    };
  end

  // with the clock monitor off, alarm bits and pins come from one latch so a read agrees with the pins; with it on the pins follow the synced clocks
  always_comb begin
    if (alarm_pin_clock_monitor_enable) begin
      photodiode_alarm_pin = pd_clock_synced;
      emitter_alarm_pin = emitter_clock_synced;
    end else begin
      photodiode_alarm_pin = fault_view.photodiode_alarm;
      emitter_alarm_pin = fault_view.emitter_alarm;
    end
  end

  // address compare kept apart from the data mux
  always_comb begin
    hit_second_ambient = rd_addr == result_flags_pkg::ADDR_SECOND_AMBIENT;
    hit_first_net = rd_addr == result_flags_pkg::ADDR_FIRST_NET;
    hit_second_net = rd_addr == result_flags_pkg::ADDR_SECOND_NET;
    hit_fault_flags = rd_addr == result_flags_pkg::ADDR_FAULT_FLAGS;
  end

  // unmapped words read zero; same-cycle update and read returns the old word
  always_comb begin
    next_rd_data = rd_data;
    if (rd_en) begin
      if (hit_second_ambient) begin
        next_rd_data = second_led_ambient_sample;
      end else if (hit_first_net) begin
        next_rd_data = first_led_net_sample;
      end else if (hit_second_net) begin
        next_rd_data = second_led_net_sample;
      end else if (hit_fault_flags) begin
        next_rd_data = fault_flags;
      end else begin
        next_rd_data = result_flags_pkg::READ_UNMAPPED;
      end
    end
  end

  // read data holds between reads
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= result_flags_pkg::RESULT_RESET;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // every word here is read-only, so the write port is taken and dropped
  always_comb begin
    unused_write = wr_en ^ (^wr_addr) ^ (^wr_data);
  end

endmodule

// two-stage synchroniser for a level or clock from another domain
module level_synchroniser #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic async_in,
  output logic sync_out
);

  logic [1:0] stages;
  logic [1:0] next_stages;

  // only the second stage is read; the first may still be settling
  always_comb begin
    next_stages = {stages[0], async_in};
  end

  // reset level chosen to match the idle level of the source
  always_ff @(posedge clk) begin
    if (srst) begin
      stages <= {2{RESET_LEVEL}};
    end else begin
      stages <= next_stages;
    end
  end

  always_comb begin
    sync_out = stages[1];
  end

endmodule

`default_nettype wire

// File: test/result_flags_sva.sv
// port assertions for the result and fault flag bank
`timescale 1ns/1ps
`default_nettype none
module result_flags_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic conv_valid,
  input wire result_flags_pkg::conversion_s conv,
  input wire logic fault_flags_done,
  input wire logic alarm_pin_clock_monitor_enable,
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  input wire logic [23:0] rd_data,
  input wire logic data_ready,
  input wire logic diagnostic_complete_pin,
  input wire logic photodiode_alarm_pin,
  input wire logic emitter_alarm_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [23:0] amb;
  logic [23:0] net2;
  always_ff @(posedge clk) begin
    if (srst) begin
      amb <= 24'h000000;
      net2 <= 24'h000000;
    end else if (conv_valid) begin
      amb <= conv.second_ambient;
      net2 <= conv.second_led - conv.second_ambient;
    end
  end
  // same-cycle updates return old data, so such reads are left out
  sequence rd_at(logic [7:0] a);
    rd_en && rd_addr == a && !conv_valid && !fault_flags_done;
  endsequence
  sequence flag_read;
    rd_at(8'h30) ##0 !alarm_pin_clock_monitor_enable;
  endsequence
  a_ready_pulse: assert property (conv_valid |=> data_ready) else $error("no ready");
  a_ready_cause: assert property (data_ready |-> $past(conv_valid)) else $error("ready");
  a_done_pulse: assert property (fault_flags_done |=> diagnostic_complete_pin) else $error("no done");
  a_done_cause: assert property (diagnostic_complete_pin |-> $past(fault_flags_done)) else $error("done");
  a_ambient_read: assert property (rd_at(8'h2D) |=> rd_data == $past(amb)) else $error("amb");
  a_net_read: assert property (rd_at(8'h2F) |=> rd_data == $past(net2)) else $error("net");
  a_upper_zero: assert property (rd_at(8'h30) |=> rd_data[23:13] == 11'h000) else $error("hi");
  a_pd_mirror: assert property (flag_read |=> rd_data[12] == $past(photodiode_alarm_pin))
    else $error("pd bit");
  a_flags_hold: assert property ((!fault_flags_done && !alarm_pin_clock_monitor_enable) ##1
    !alarm_pin_clock_monitor_enable |-> $stable({photodiode_alarm_pin, emitter_alarm_pin}))
    else $error("pins moved");
endmodule
bind sample_result_and_fault_flags result_flags_sva chk (.*);
`default_nettype wire

// File: test/host_model.sv
// host side reading the bank one word at a time
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk,
  output logic rd_en,
  output logic [7:0] rd_addr,
  input wire logic [23:0] rd_data
);
  initial {rd_en, rd_addr} = 9'h000;
  // result read before the next conversion lands
  task automatic rd(input logic [7:0] a, output logic [23:0] d);
    @(posedge clk) {rd_en, rd_addr} <= {1'b1, a};
    // idle address flipped so a stale address cannot pass
    @(posedge clk) {rd_en, rd_addr} <= {1'b0, ~a};
    #1 d = rd_data; // raw value, software flips the sign
  endtask
endmodule
`default_nettype wire

// File: test/sample_result_and_fault_flags_test.sv
// self-checking bench for the result and fault flag bank
`timescale 1ns/1ps
`default_nettype none
module sample_result_and_fault_flags_test;
  logic clk = 0, srst = 1, cv = 0, dd = 0, en = 0, we = 0, rd_en, dr, dp, pa, ea;
  logic [7:0] rd_addr;
  logic [23:0] rd_data, v;
  result_flags_pkg::conversion_s c = '0;
  result_flags_pkg::fault_s f = '0;
  int fails = 0, checks = 0, cyc = 0;
  always #12.5 clk = ~clk;
  sample_result_and_fault_flags dut (.clk, .srst, .conv_valid(cv), .conv(c), .fault_flags_done(dd),
    .fault_levels(f), .alarm_pin_clock_monitor_enable(en), .monitor_clock_pd(1'b0),
    .monitor_clock_emitter(1'b1), .rd_en, .rd_addr, .wr_en(we), .wr_addr(8'h30),
    .wr_data(24'hFFFFFF), .rd_data, .data_ready(dr), .diagnostic_complete_pin(dp),
    .photodiode_alarm_pin(pa), .emitter_alarm_pin(ea));
  host_model h (.clk, .rd_en, .rd_addr, .rd_data);
  task automatic chk(string n, logic [23:0] s, logic [23:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic rdc(logic [7:0] a, logic [23:0] e);
    h.rd(a, v);
    chk($sformatf("reg %h", a), v, e);
  endtask
  task automatic t_reset();
    @(posedge clk) srst <= 1;
    repeat (2) @(posedge clk);
    srst <= 0;
    for (int a = 8'h2D; a < 8'h32; a++) rdc(8'(a), 24'h0);
    $display("reset test done");
  endtask
  task automatic t_conv();
    @(posedge clk) {cv, c} <= {1'b1, 96'h000010_000020_111111_222222};
    @(posedge clk) c <= {24'h000001, 24'h000002, 24'h300000, 24'h100000};
    #1 chk("data_ready", 24'(dr), 24'h1);
    @(posedge clk) cv <= 0;
    #1 chk("data_ready", 24'(dr), 24'h1);
    rdc(8'h2D, 24'h100000);
    rdc(8'h2E, 24'hFFFFFF);
    rdc(8'h2F, 24'h200000);
    $display("conversion test done");
  endtask
  task automatic t_fault_flags();
    for (int i = 0; i < 13; i++) begin
      @(posedge clk) {dd, f} <= {1'b1, 13'(1 << i)};
      @(posedge clk) dd <= 0;
      #1 chk("fault_flags_pin", 24'(dp), 24'h1);
      chk("alarm_pins", 24'({pa, ea}), 24'(f[12:11]));
      rdc(8'h30, 24'(1 << i));
    end
    @(posedge clk) {we, f, en} <= {1'b1, 13'h0, 1'b1};
    @(posedge clk) we <= 0;
    #1 chk("monitor_pins", 24'({pa, ea}), 24'h1);
    rdc(8'h30, 24'h001000);
    $display("diagnostic test done");
  endtask
  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    t_reset();
    t_conv();
    t_fault_flags();
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire
